// [src/usbc_ep_cfg.sv]
// USB module configuration, power state and per-endpoint control.
// Notes on behaviour
// R1: Eye-pattern test runs on the lines while the eye-test enable bit is set.
// R2: Monitor bit set drives active-low output enable while lines are driven.
// R3: Stop-in-idle set halts the module in chip Idle; clear keeps it running.
// R4: Auto-suspend set suspends the module when the chip enters Sleep.
// R5: Auto-suspend clear: only the suspend control stops module and 48 MHz clock.
// R6: Host mode, endpoint 0: low-speed direct bit chooses direct or PRE PID.
// R7: Host mode, endpoint 0: NACKed transactions retried unless retry disabled.
// R8: With RX and TX enabled, control-disable set forbids SETUP transfers.
// R9: Endpoint accepts receive transfers only while receive enable is set.
// R10: Endpoint transmits only while transmit enable is set.
// R11: Stall status bit reads one after the endpoint was stalled.
// R12: Handshakes happen only while handshake enable is set.
// R13: Upper and unimplemented bits read zero; sixteen endpoint registers exist.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns
module usbc_ep_cfg
  import usbc_pkg::*;
(
  input wire logic CLK, // Clock, 20 MHz.
  input wire logic RST, // Asynchronous reset, active high.
  input wire logic [7:0] ADDR, // Register byte address.
  input wire logic [31:0] WDATA, // Write data.
  input wire logic WR, // Write strobe.
  input wire logic RD, // Read strobe.
  output logic [31:0] RDATA, // Read data, cycle after the strobe.
  input wire usbc_tok_type TOKEN, // Token from the serial engine.
  input wire usbc_stall_type STALL_EVT, // Engine reports an endpoint stall.
  input wire logic HOST_MODE, // Module acts as host.
  input wire logic TX_DRIVE, // Engine drives D+ and D-.
  input wire logic SLEEP_IN, // Chip in Sleep, from another domain.
  input wire logic IDLE_IN, // Chip in Idle, from another domain.
  output usbc_verdict_type VERDICT, // Verdict on a token.
  output logic EYE_DP, // Eye-pattern level on D+.
  output logic EYE_DM, // Eye-pattern level on D-.
  output logic OE_N, // Line driver enable monitor, active low.
  output logic CLK48_EN, // Enable of the 48 MHz clock.
  output logic SUSPENDED, // Module suspended.
  output logic HALTED // Module halted in Idle.
);

  // ----------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------
  function automatic logic ep_hit(input logic [7:0] a);
    ep_hit = (a & EP_WIN_MASK) == OFS_EP_BASE;
  endfunction

  function automatic logic [3:0] ep_idx(input logic [7:0] a);
    ep_idx = a[EP_IDX_LSB +: EP_IDX_W];
  endfunction

  logic sleep_s1_q;
  logic sleep_q;
  logic idle_s1_q;
  logic idle_q;
  logic [7:0] cnfg_q;
  logic pwrc_susp_q;
  usbc_state_type state_q;
  usbc_state_type state_d;
  logic suspend_req;
  logic idle_halt_req;
  logic [NUM_EP-1:0] stall_q;
  logic ep_wr;
  logic [7:0] ep_rd_bus;
  logic [7:0] ep_rd_tok;
  logic rd_ep_q;
  logic [31:0] rd_misc_q;
  usbc_tok_type tok_q;
  logic eye_ph_q;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sleep_s1_q <= 1'b0;
      sleep_q <= 1'b0;
      idle_s1_q <= 1'b0;
      idle_q <= 1'b0;
    end
    else
    begin
      // Logic reads only the second stage of each synchroniser.
      sleep_s1_q <= SLEEP_IN;
      sleep_q <= sleep_s1_q;
      idle_s1_q <= IDLE_IN;
      idle_q <= idle_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and power control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      cnfg_q <= RST_VAL;
    end
    else if (WR && ADDR == OFS_CNFG)
    begin
      cnfg_q <= WDATA[REG_W-1:0] & CNFG_MASK; // R13
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pwrc_susp_q <= 1'b0;
    end
    else if (WR && ADDR == OFS_PWRC)
    begin
      // Only the suspend bit of the power control word is kept.
      pwrc_susp_q <= WDATA[PWRC_SUSP];
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  // Suspend outranks the Idle halt, so software suspend always stops the clock.
  assign suspend_req = pwrc_susp_q | (cnfg_q[CNFG_ASUSP] & sleep_q); // R4 R5
  assign idle_halt_req = idle_q & cnfg_q[CNFG_SIDL]; // R3

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN:
      begin
        if (suspend_req)
          state_d = ST_SUSPEND;
        else if (idle_halt_req)
          state_d = ST_IDLE_HALT; // R3
      end
      ST_IDLE_HALT:
      begin
        if (suspend_req)
          state_d = ST_SUSPEND;
        else if (!idle_halt_req)
          state_d = ST_RUN; // R3
      end
      ST_SUSPEND:
      begin
        if (!suspend_req)
          state_d = ST_RUN; // R5
      end
      default:
      begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= ST_RUN;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      SUSPENDED <= 1'b0;
      HALTED <= 1'b0;
      CLK48_EN <= 1'b1;
    end
    else
    begin
      SUSPENDED <= state_d == ST_SUSPEND; // R4
      HALTED <= state_d == ST_IDLE_HALT; // R3
      CLK48_EN <= state_d != ST_SUSPEND; // R5
    end
  end

  // ----------------------------------------------------------------
  // Endpoint control words
  // ----------------------------------------------------------------
  // Endpoint words keep every bit but bit 5 and the stall bit, which lives in its own flops.
  assign ep_wr = WR && ep_hit(ADDR);

  usbc_ep_mem u_mem (
    .clk(CLK),
    .rst(RST),
    .wr_en(ep_wr),
    .wr_idx(ep_idx(ADDR)),
    .wr_data(WDATA[REG_W-1:0] & EP_STORE_MASK), // R13
    .rd_a_idx(ep_idx(ADDR)),
    .rd_a_data(ep_rd_bus),
    .rd_b_idx(TOKEN.ep),
    .rd_b_data(ep_rd_tok)
  );

  // A stall reported in the cycle software writes the bit still sets it.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi++)
    begin : g_stall
      always_ff @(posedge CLK or posedge RST)
      begin
        if (RST)
        begin
          stall_q[gi] <= 1'b0;
        end
        else if (STALL_EVT.valid && STALL_EVT.ep == EP_IDX_W'(gi))
        begin
          stall_q[gi] <= 1'b1; // R11
        end
        else if (ep_wr && ep_idx(ADDR) == EP_IDX_W'(gi))
        begin
          stall_q[gi] <= WDATA[EP_STALL];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rd_ep_q <= 1'b0;
      rd_misc_q <= '0;
    end
    else
    begin
      rd_ep_q <= RD && ep_hit(ADDR);
      rd_misc_q <= '0;
      if (RD)
      begin
        if (ADDR == OFS_CNFG)
          rd_misc_q[REG_W-1:0] <= cnfg_q; // R13
        else if (ADDR == OFS_PWRC)
          rd_misc_q[PWRC_SUSP] <= pwrc_susp_q;
        else if (ADDR == OFS_STAT)
        begin
          rd_misc_q[STAT_SUSP] <= state_q == ST_SUSPEND;
          rd_misc_q[STAT_HALT] <= state_q == ST_IDLE_HALT;
          rd_misc_q[STAT_SLEEP] <= sleep_q;
          rd_misc_q[STAT_IDLE] <= idle_q;
        end
        else if (ep_hit(ADDR))
          rd_misc_q[EP_STALL] <= stall_q[ep_idx(ADDR)]; // R11
      end
    end
  end

  // Both read sources are registered, so the data stand only in the cycle after the strobe.
  assign RDATA = rd_misc_q | (rd_ep_q ? {24'h00_0000, ep_rd_bus} : 32'h0000_0000); // R13

  // ----------------------------------------------------------------
  // Token verdicts
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      tok_q <= '0;
    end
    else
    begin
      tok_q <= TOKEN;
    end
  end

  // Control-disable only matters when both directions of the endpoint are enabled.
  function automatic logic kind_allowed(input usbc_kind_type k, input logic [7:0] w);
    logic both;
    both = w[EP_RXEN] & w[EP_TXEN];
    unique case (k)
      TK_OUT: kind_allowed = w[EP_RXEN]; // R9
      TK_IN: kind_allowed = w[EP_TXEN]; // R10
      TK_SETUP: kind_allowed = both & ~w[EP_CONDIS]; // R8
      default: kind_allowed = 1'b0;
    endcase
  endfunction

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      VERDICT <= '0;
    end
    else
    begin
      VERDICT.valid <= tok_q.valid;
      VERDICT.ep <= tok_q.ep;
      VERDICT.accept <= tok_q.valid && state_q == ST_RUN && kind_allowed(tok_q.kind, ep_rd_tok);
      VERDICT.handshake <= ep_rd_tok[EP_HSHK]; // R12
      // Host-only fields stay low for every endpoint other than endpoint 0.
      VERDICT.retry <= HOST_MODE && tok_q.ep == EP_ZERO && !ep_rd_tok[EP_NO_RETRY]; // R7
      VERDICT.ls_direct <= HOST_MODE && tok_q.ep == EP_ZERO && tok_q.low_speed && ep_rd_tok[EP_LS_DIRECT]; // R6
      VERDICT.pre_pid <= HOST_MODE && tok_q.ep == EP_ZERO && tok_q.low_speed && !ep_rd_tok[EP_LS_DIRECT]; // R6
      // The stall bit is read live, so a stall reported just before the token shows at once.
      VERDICT.stalled <= stall_q[tok_q.ep];
    end
  end

  // ----------------------------------------------------------------
  // Eye pattern and output enable monitor
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      eye_ph_q <= 1'b0;
      EYE_DP <= 1'b0;
      EYE_DM <= 1'b0;
    end
    else if (cnfg_q[CNFG_EYE] && state_q == ST_RUN)
    begin
      // The phase toggles every cycle, so D+ and D- swap levels on each clock.
      eye_ph_q <= ~eye_ph_q; // R1
      EYE_DP <= eye_ph_q;
      EYE_DM <= ~eye_ph_q;
    end
    else
    begin
      eye_ph_q <= 1'b0;
      EYE_DP <= 1'b0;
      EYE_DM <= 1'b0;
    end
  end

  // The eye pattern drives the lines too, so it counts as driving.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      OE_N <= 1'b1;
    end
    else
    begin
      OE_N <= !(cnfg_q[CNFG_OEMON] && state_q == ST_RUN && (TX_DRIVE || cnfg_q[CNFG_EYE])); // R2
    end
  end

endmodule

// [src/usbc_pkg.sv]
// Shared constants and types for the USB endpoint configuration block.
package usbc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam logic [7:0] OFS_CNFG = 8'h00;
  localparam logic [7:0] OFS_PWRC = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_EP_BASE = 8'h40;
  localparam logic [7:0] EP_WIN_MASK = 8'hC3;
  localparam int EP_IDX_LSB = 2;
  localparam int NUM_EP = 16;
  localparam int EP_IDX_W = 4;
  localparam logic [3:0] EP_ZERO = 4'h0;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int CNFG_EYE = 7;
  localparam int CNFG_OEMON = 6;
  localparam int CNFG_SIDL = 4;
  localparam int CNFG_ASUSP = 0;
  localparam logic [7:0] CNFG_MASK = 8'hD1;
  localparam int PWRC_SUSP = 1;
  localparam logic [7:0] PWRC_MASK = 8'h02;
  localparam int EP_LS_DIRECT = 7;
  localparam int EP_NO_RETRY = 6;
  localparam int EP_CONDIS = 4;
  localparam int EP_RXEN = 3;
  localparam int EP_TXEN = 2;
  localparam int EP_STALL = 1;
  localparam int EP_HSHK = 0;
  localparam logic [7:0] EP_MASK = 8'hDF;
  localparam logic [7:0] EP_STORE_MASK = 8'hDD;
  localparam int STAT_SUSP = 0;
  localparam int STAT_HALT = 1;
  localparam int STAT_SLEEP = 2;
  localparam int STAT_IDLE = 3;
  localparam logic [7:0] RST_VAL = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TK_OUT = 3'b001,
    TK_IN = 3'b010,
    TK_SETUP = 3'b100
  } usbc_kind_type;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_IDLE_HALT = 3'b010,
    ST_SUSPEND = 3'b100
  } usbc_state_type;

  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    usbc_kind_type kind;
    logic low_speed;
  } usbc_tok_type;

  typedef struct packed {
    logic valid;
    logic [3:0] ep;
  } usbc_stall_type;

  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    logic accept;
    logic handshake;
    logic retry;
    logic ls_direct;
    logic pre_pid;
    logic stalled;
  } usbc_verdict_type;

endpackage

// [src/usbc_ep_mem.sv]
// Sixteen endpoint control words with two registered read ports.
`timescale 1ns/1ns
module usbc_ep_mem
  import usbc_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic wr_en, // Write one word.
  input wire logic [3:0] wr_idx, // Word written.
  input wire logic [7:0] wr_data, // Data written.
  input wire logic [3:0] rd_a_idx, // Bus read index.
  output logic [7:0] rd_a_data, // Bus read data, one cycle later.
  input wire logic [3:0] rd_b_idx, // Token read index.
  output logic [7:0] rd_b_data // Token read data, one cycle later.
);

  logic [7:0] mem_q [NUM_EP];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_EP; i++)
      begin
        mem_q[i] <= RST_VAL;
      end
    end
    else if (wr_en)
    begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_a_data <= RST_VAL;
      rd_b_data <= RST_VAL;
    end
    else
    begin
      rd_a_data <= mem_q[rd_a_idx];
      rd_b_data <= mem_q[rd_b_idx];
    end
  end

endmodule

// [verif/usbc_eng_model.sv]
// Behavioural serial engine that feeds tokens and stall reports to the block.
`timescale 1ns/1ns
module usbc_eng_model
  import usbc_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic go, // Send a token next cycle.
  input wire logic [3:0] ep, // Endpoint of the token.
  input wire usbc_kind_type kind, // Kind of the token.
  input wire logic sgo, // Report a stall next cycle.
  input wire logic [3:0] sep, // Endpoint that stalled.
  output usbc_tok_type tok = '0, // Token to the block.
  output usbc_stall_type stl = '0 // Stall report to the block.
);
  // Endpoint and speed fields outside a valid pulse keep changing so that nothing relies on stale values.
  always @(posedge clk)
  begin
    if (go)
      tok <= '{1'b1, ep, kind, 1'b1};
    else
      tok <= '{1'b0, ~tok.ep, tok.kind, ~tok.low_speed};
    stl.valid <= sgo;
    stl.ep <= sgo ? sep : ~stl.ep;
  end
endmodule

// [verif/usbc_ep_cfg_sva.sv]
// Port assertions for the endpoint configuration block.
`timescale 1ns/1ns
module usbc_ep_cfg_sva
  import usbc_pkg::*;
(
  input wire logic CLK, // Clock.
  input wire logic RST, // Reset.
  input wire logic [7:0] ADDR, // Address.
  input wire logic RD, // Read strobe.
  input wire logic [31:0] RDATA, // Read data.
  input wire usbc_tok_type TOKEN, // Token.
  input wire usbc_stall_type STALL_EVT, // Stall report.
  input wire logic HOST_MODE, // Host mode.
  input wire usbc_verdict_type VERDICT, // Verdict.
  input wire logic EYE_DP, // Eye level on D+.
  input wire logic CLK48_EN, // Clock enable.
  input wire logic SUSPENDED, // Suspended.
  input wire logic HALTED // Halted.
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  property p_rd_idle;
    !RD |=> RDATA == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
  property p_rd_upper;
    RD |=> RDATA[31:8] == 24'h00_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_tok_lat;
    TOKEN.valid |-> ##2 (VERDICT.valid && VERDICT.ep == $past(TOKEN.ep, 2));
  endproperty
  a_tok_lat: assert property (p_tok_lat) else $error("verdict missing or wrong endpoint");
  property p_no_spur;
    !TOKEN.valid |-> ##2 !VERDICT.valid;
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("verdict without token");
  property p_ep0_only;
    VERDICT.valid && VERDICT.ep != 4'h0 |-> !(VERDICT.retry || VERDICT.ls_direct || VERDICT.pre_pid);
  endproperty
  a_ep0_only: assert property (p_ep0_only) else $error("host fields on other endpoint");
  property p_guest;
    VERDICT.valid && !$past(HOST_MODE) |-> !(VERDICT.retry || VERDICT.ls_direct || VERDICT.pre_pid);
  endproperty
  a_guest: assert property (p_guest) else $error("host fields outside host mode");
  property p_susp_refuse;
    VERDICT.valid && $past(SUSPENDED, 2) && $past(SUSPENDED) |-> !VERDICT.accept;
  endproperty
  a_susp_refuse: assert property (p_susp_refuse) else $error("token accepted while suspended");
  property p_clk48;
    CLK48_EN != SUSPENDED;
  endproperty
  a_clk48: assert property (p_clk48) else $error("clock enable disagrees with suspend");
  property p_eye_alt;
    EYE_DP |=> !EYE_DP;
  endproperty
  a_eye_alt: assert property (p_eye_alt) else $error("eye pattern not alternating");
  property p_excl;
    HALTED |-> !SUSPENDED;
  endproperty
  a_excl: assert property (p_excl) else $error("halted and suspended together");
  property p_stall;
    STALL_EVT.valid ##1 (RD && ADDR == OFS_EP_BASE + {2'b00, $past(STALL_EVT.ep), 2'b00}) |=> RDATA[1];
  endproperty
  a_stall: assert property (p_stall) else $error("stall status not set");
  c_accept: cover property (VERDICT.valid && VERDICT.accept);
  c_susp: cover property ($rose(SUSPENDED));
  c_halt: cover property ($rose(HALTED));
endmodule

bind usbc_ep_cfg usbc_ep_cfg_sva chk (.CLK(CLK), .RST(RST), .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .TOKEN(TOKEN),
  .STALL_EVT(STALL_EVT), .HOST_MODE(HOST_MODE), .VERDICT(VERDICT), .EYE_DP(EYE_DP), .CLK48_EN(CLK48_EN),
  .SUSPENDED(SUSPENDED), .HALTED(HALTED));

// [verif/test_usbc_ep_cfg.sv]
// Self-checking testbench for the endpoint configuration block.
`timescale 1ns/1ns
module test_usbc_ep_cfg;
  import usbc_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, host = 1, txd = 0, sleep = 0, idle = 0, go = 0, sgo = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, seed = 32'h1d3e_eed3;
  logic [3:0] gep = 4'h0, sep = 4'h0;
  logic eye_dp, eye_dm, oe_n, clk48, susp, halt, e0, ph;
  logic [4:0] outs;
  logic [7:0] tw[4] = '{8'hdd, 8'h1c, 8'h48, 8'h85};
  usbc_kind_type gkind = TK_OUT;
  usbc_tok_type tok;
  usbc_stall_type stl;
  usbc_verdict_type verdict;
  int bad_count = 0, checked = 0;
  int ep_m[16] = '{default: 0};
  logic [31:0] expq[$];
  always #25 clk = ~clk;
  usbc_eng_model eng (.clk(clk), .go(go), .ep(gep), .kind(gkind), .sgo(sgo), .sep(sep), .tok(tok), .stl(stl));
  usbc_ep_cfg dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .TOKEN(tok), .STALL_EVT(stl), .HOST_MODE(host), .TX_DRIVE(txd), .SLEEP_IN(sleep), .IDLE_IN(idle),
    .VERDICT(verdict), .EYE_DP(eye_dp), .EYE_DM(eye_dm), .OE_N(oe_n), .CLK48_EN(clk48), .SUSPENDED(susp),
    .HALTED(halt));
  assign outs = {eye_dp, oe_n, halt, clk48, susp};
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a[7:6] == 2'b01 && a[1:0] == 2'b00)
      ep_m[a[5:2]] = int'(d[7:0] & EP_MASK);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
  endtask
  task automatic send(input logic [3:0] e, input usbc_kind_type k);
    logic [7:0] w;
    logic a;
    w = 8'(ep_m[e]);
    a = (k == TK_OUT) ? w[3] : (k == TK_IN) ? w[2] : (w[3] & w[2] & !w[4]);
    e0 = host && e == 4'h0;
    expq.push_back(32'({1'b1, e, a & !susp & !halt, w[0], e0 & !w[6], e0 & w[7], e0 & !w[7], w[1]}));
    @(posedge clk);
    gep <= e;
    gkind <= k;
    go <= 1'b1;
  endtask
  task automatic burst(input logic [3:0] e);
    send(e, TK_OUT);
    send(e, TK_IN);
    send(e, TK_SETUP);
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    check(expq.size(), 0);
  endtask
  task automatic pin(input int sel, input logic exp);
    repeat (5) @(posedge clk);
    @(negedge clk);
    check(32'(outs[sel]), 32'(exp));
  endtask
  always @(negedge clk)
  begin
    if (verdict.valid === 1'b1)
      check(32'(verdict), expq.size() ? expq.pop_front() : 32'hffff_ffff);
  end
  initial
  begin
    #200_000;
    bad_count++;
    end_sim();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < NUM_EP; i++)
      rd_reg(OFS_EP_BASE + 8'(4 * i), 32'h0000_0000);
    wr_reg(8'h0c, 32'hffff_ffff);
    rd_reg(8'h0c, 32'h0000_0000);
    rd_reg(OFS_CNFG, 32'h0000_0000);
    $display("test reset and unmapped done");
    for (int i = 0; i < NUM_EP; i++)
    begin
      seed = lfsr(seed);
      wr_reg(OFS_EP_BASE + 8'(4 * i), seed);
      rd_reg(OFS_EP_BASE + 8'(4 * i), 32'(ep_m[i]));
      burst(4'(i));
    end
    for (int h = 0; h < 2; h++)
      for (int j = 0; j < 4; j++)
      begin
        host <= h[0];
        wr_reg(OFS_EP_BASE, {24'hff_ffff, tw[j]});
        burst(4'h0);
      end
    $display("test tokens done");
    @(posedge clk);
    sgo <= 1'b1;
    sep <= 4'h5;
    @(posedge clk);
    sgo <= 1'b0;
    ep_m[5] = ep_m[5] | 2;
    rd_reg(OFS_EP_BASE + 8'h14, 32'(ep_m[5]));
    burst(4'h5);
    $display("test stall done");
    wr_reg(OFS_CNFG, 32'hffff_ff80);
    repeat (5) @(posedge clk);
    @(negedge clk);
    ph = eye_dp;
    @(negedge clk);
    check(32'(eye_dp), 32'(!ph));
    check(32'(eye_dm), 32'(ph));
    wr_reg(OFS_CNFG, 32'h0000_0040);
    txd <= 1'b1;
    pin(3, 1'b0);
    wr_reg(OFS_CNFG, 32'h0000_0000);
    pin(3, 1'b1);
    check(32'(eye_dp), 32'h0000_0000);
    check(32'(eye_dm), 32'h0000_0000);
    $display("test eye and monitor done");
    idle <= 1'b1;
    pin(2, 1'b0);
    wr_reg(OFS_CNFG, 32'h0000_0010);
    pin(2, 1'b1);
    rd_reg(OFS_STAT, 32'h0000_000a);
    burst(4'h3);
    idle <= 1'b0;
    wr_reg(OFS_CNFG, 32'h0000_0000);
    wr_reg(OFS_PWRC, 32'h0000_0002);
    pin(1, 1'b0);
    rd_reg(OFS_STAT, 32'h0000_0001);
    burst(4'h0);
    wr_reg(OFS_PWRC, 32'h0000_0000);
    sleep <= 1'b1;
    pin(0, 1'b0);
    wr_reg(OFS_CNFG, 32'h0000_0001);
    pin(0, 1'b1);
    rd_reg(OFS_STAT, 32'h0000_0005);
    $display("test power done");
    end_sim();
  end
endmodule
